// File: design/sst_pkg.sv
package sst_pkg;
  // Register indices on the plain register port.
  localparam logic [2:0] SST_REG_DATA = 3'h0;
  localparam logic [2:0] SST_REG_STATUS = 3'h1;
  localparam logic [2:0] SST_REG_CTRL1 = 3'h2;
  localparam logic [2:0] SST_REG_CTRL2 = 3'h3;
  localparam logic [2:0] SST_REG_CTRL3 = 3'h4;
  localparam logic [2:0] SST_REG_IRQ = 3'h5;
  localparam logic [2:0] SST_REG_MASK = 3'h6;
  localparam logic [2:0] SST_REG_ADDR = 3'h7;
  // Status register bits.
  localparam int SST_ST_BF = 0;
  localparam int SST_ST_RW = 2;
  localparam int SST_ST_START = 3;
  localparam int SST_ST_STOP = 4;
  localparam int SST_ST_ADDRESSED = 5;
  // Control one: clock release bit.
  localparam int SST_C1_CKR = 4;
  // Control two: acknowledge status bit.
  localparam int SST_C2_ACK = 6;
  // Control three bits.
  localparam int SST_C3_SLAVE_COLLISION_DETECT_EN = 2;
  localparam int SST_C3_SCIE = 5;
  // Interrupt status bits.
  localparam int SST_IRQ_SER = 0;
  localparam int SST_IRQ_COL = 1;
  localparam logic [7:0] SST_RST_CTRL1 = 8'h10;
  localparam logic [6:0] SST_RST_ADDR = 7'h2a;
  localparam logic [3:0] SST_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] SST_ACK_BIT = 4'h9;
  typedef enum logic [2:0] {
    SST_IDLE = 3'b000,
    SST_ADDR = 3'b001,
    SST_AACK = 3'b010,
    SST_HOLD = 3'b011,
    SST_SEND = 3'b100,
    SST_MACK = 3'b101
  } sst_state_t;
endpackage

// File: design/sst_slave_tx.sv
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module sst_slave_tx
  import sst_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);

  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic scl_r;
  logic sda_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Three-stage synchronisers; a level counts once stages two and three agree.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], scl_in};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      if (scl_sync_r[1] == scl_sync_r[2]) begin
        scl_r <= scl_sync_r[2];
      end
      if (sda_sync_r[1] == sda_sync_r[2]) begin
        sda_r <= sda_sync_r[2];
      end
    end
  end

  logic scl_q;
  logic sda_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_r;
      sda_q <= sda_r;
    end
  end

  assign scl_rise = scl_r & ~scl_q;
  assign scl_fall = ~scl_r & scl_q;
  assign start_det = scl_r & scl_q & sda_q & ~sda_r;
  assign stop_det = scl_r & scl_q & ~sda_q & sda_r;

  sst_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] data_buf_r;
  logic buffer_full_r;
  logic rw_r;
  logic start_r;
  logic stop_r;
  logic addressed_r;
  logic ack_status_r;
  logic clock_release_r;
  logic scl_hold_r;
  logic sda_drive_low_r;
  logic [7:0] ctrl3_r;
  logic [6:0] own_addr_r;
  logic [1:0] irq_st_r;
  logic [1:0] irq_mask_r;
  logic ser_set;
  logic col_set;
  logic buf_wr;
  logic rel_wr;
  logic collision;
  logic addr_match;

  assign buf_wr = reg_wr && (reg_addr == SST_REG_DATA);
  assign rel_wr = reg_wr && (reg_addr == SST_REG_CTRL1) && reg_wdata[SST_C1_CKR];
  assign addr_match = (shift_r[7:1] == own_addr_r);
  // Driving a one means releasing SDA; seeing it low at SCL rise is a lost bit.
  assign collision = (state_r == SST_SEND) && scl_rise && ~sda_drive_low_r && ~sda_r;

  // Byte sequencer.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SST_IDLE;
      bit_cnt_r <= 4'h0;
    end else if (start_det) begin
      state_r <= SST_ADDR;
      bit_cnt_r <= 4'h0;
    end else if (stop_det) begin
      state_r <= SST_IDLE;
    end else begin
      case (state_r)
        SST_IDLE: begin
          bit_cnt_r <= 4'h0;
        end
        SST_ADDR: begin
          if (scl_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          if (scl_fall && bit_cnt_r == SST_BITS_PER_BYTE) begin
            if (addr_match && shift_r[0]) begin
              state_r <= SST_AACK;
            end else begin
              state_r <= SST_IDLE;
            end
          end
        end
        SST_AACK: begin
          if (scl_fall) begin
            state_r <= SST_HOLD;
            bit_cnt_r <= 4'h0;
          end
        end
        SST_HOLD: begin
          if (!scl_hold_r) begin
            state_r <= SST_SEND;
          end
        end
        SST_SEND: begin
          if (collision && ctrl3_r[SST_C3_SLAVE_COLLISION_DETECT_EN]) begin
            state_r <= SST_IDLE;
          end else if (scl_fall) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == SST_BITS_PER_BYTE - 4'h1) begin
              state_r <= SST_MACK;
            end
          end
        end
        SST_MACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            state_r <= ack_status_r ? SST_IDLE : SST_HOLD;
          end
        end
        default: begin
          state_r <= SST_IDLE;
        end
      endcase
    end
  end

  // Shift register: samples address bits, or is loaded by software.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= 8'h00;
    end else if (buf_wr) begin
      shift_r <= reg_wdata;
    end else if (state_r == SST_ADDR && scl_rise) begin
      shift_r <= {shift_r[6:0], sda_r};
    end else if (state_r == SST_SEND && scl_fall) begin
      shift_r <= {shift_r[6:0], 1'b0};
    end
  end

  // SDA is changed only while SCL is low, so it stands through each high phase.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_drive_low_r <= 1'b0;
    end else if (state_r == SST_ADDR && scl_fall && bit_cnt_r == SST_BITS_PER_BYTE
                 && addr_match && shift_r[0]) begin
      sda_drive_low_r <= 1'b1;
    end else if (state_r == SST_HOLD) begin
      sda_drive_low_r <= ~shift_r[7];
    end else if (state_r == SST_SEND && scl_fall) begin
      if (bit_cnt_r == SST_BITS_PER_BYTE - 4'h1) begin
        sda_drive_low_r <= 1'b0;
      end else begin
        sda_drive_low_r <= ~shift_r[6];
      end
    end else if (state_r == SST_IDLE || state_r == SST_MACK
                 || (state_r == SST_AACK && scl_fall)) begin
      sda_drive_low_r <= 1'b0;
    end
  end

  // Clock release bit and the SCL hold it controls.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clock_release_r <= SST_RST_CTRL1[SST_C1_CKR];
      scl_hold_r <= 1'b0;
    end else if (rel_wr) begin
      clock_release_r <= 1'b1;
      scl_hold_r <= 1'b0;
    end else if ((state_r == SST_AACK && scl_fall)
                 || (state_r == SST_MACK && scl_fall && !ack_status_r)) begin
      clock_release_r <= 1'b0;
      scl_hold_r <= 1'b1;
    end else if (reg_wr && reg_addr == SST_REG_CTRL1) begin
      clock_release_r <= reg_wdata[SST_C1_CKR];
    end else if (state_r == SST_IDLE) begin
      scl_hold_r <= 1'b0;
    end
  end

  // Acknowledge status is taken from SDA at the rising SCL edge in SST_MACK, as address bits are in SST_ADDR.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_status_r <= 1'b0;
    end else if (state_r == SST_MACK && scl_rise) begin
      ack_status_r <= sda_r;
    end
  end

  // Data buffer, buffer full and read/write status.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_buf_r <= 8'h00;
      buffer_full_r <= 1'b0;
      rw_r <= 1'b0;
    end else if (state_r == SST_ADDR && scl_fall && bit_cnt_r == SST_BITS_PER_BYTE
                 && addr_match && shift_r[0]) begin
      data_buf_r <= shift_r;
      buffer_full_r <= 1'b1;
      rw_r <= 1'b1;
    end else if (buf_wr) begin
      data_buf_r <= reg_wdata;
    end else if (reg_rd && reg_addr == SST_REG_DATA) begin
      buffer_full_r <= 1'b0;
    end
  end

  // Start, stop and addressed status.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_r <= 1'b0;
      stop_r <= 1'b0;
      addressed_r <= 1'b0;
    end else begin
      if (start_det) begin
        start_r <= 1'b1;
        stop_r <= 1'b0;
        addressed_r <= 1'b0;
      end else if (stop_det) begin
        start_r <= 1'b0;
        stop_r <= 1'b1;
        addressed_r <= 1'b0;
      end else if (state_r == SST_AACK) begin
        addressed_r <= 1'b1;
      end else if (state_r == SST_IDLE) begin
        addressed_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl3_r <= 8'h00;
      own_addr_r <= SST_RST_ADDR;
      irq_mask_r <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == SST_REG_CTRL3) begin
        ctrl3_r <= reg_wdata;
      end
      if (reg_addr == SST_REG_ADDR) begin
        own_addr_r <= reg_wdata[6:0];
      end
      if (reg_addr == SST_REG_MASK) begin
        irq_mask_r <= reg_wdata[1:0];
      end
    end
  end

  // Per-byte flag at the ninth falling edge, including the address byte, and at a start when SCIE is set.
  assign ser_set = (scl_fall && (state_r == SST_AACK || state_r == SST_MACK))
                   || (start_det && ctrl3_r[SST_C3_SCIE]);
  assign col_set = collision && ctrl3_r[SST_C3_SLAVE_COLLISION_DETECT_EN];

  // Sticky interrupt bits cleared by reading; a same-cycle event wins.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_st_r <= 2'h0;
    end else begin
      if (ser_set) begin
        irq_st_r[SST_IRQ_SER] <= 1'b1;
      end else if (reg_rd && reg_addr == SST_REG_IRQ) begin
        irq_st_r[SST_IRQ_SER] <= 1'b0;
      end
      if (col_set) begin
        irq_st_r[SST_IRQ_COL] <= 1'b1;
      end else if (reg_rd && reg_addr == SST_REG_IRQ) begin
        irq_st_r[SST_IRQ_COL] <= 1'b0;
      end
    end
  end

  assign irq = |(irq_st_r & irq_mask_r);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        SST_REG_DATA: reg_rdata <= data_buf_r;
        SST_REG_STATUS: reg_rdata <= {2'h0, addressed_r, stop_r, start_r, rw_r, 1'b0,
                                      buffer_full_r};
        SST_REG_CTRL1: reg_rdata <= {3'h0, clock_release_r, 4'h0};
        SST_REG_CTRL2: reg_rdata <= {1'b0, ack_status_r, 6'h00};
        SST_REG_CTRL3: reg_rdata <= ctrl3_r;
        SST_REG_IRQ: reg_rdata <= {6'h00, irq_st_r};
        SST_REG_MASK: reg_rdata <= {6'h00, irq_mask_r};
        SST_REG_ADDR: reg_rdata <= {1'b0, own_addr_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Open drain: only ever drive low.
  assign scl_out = 1'b0;
  assign scl_oe = scl_hold_r;
  assign sda_out = 1'b0;
  assign sda_oe = sda_drive_low_r;

endmodule

// File: verif/sst_i2c_master.sv
`timescale 1ns/10ps
module sst_i2c_master (
  input wire logic scl,
  input wire logic sda,
  output logic scl_lo,
  output logic sda_lo,
  output logic [8:0] rx_word
);
  localparam realtime HALF = 62.5;
  event got;
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
    rx_word = 9'h000;
  end
  task automatic start_cond();
    sda_lo = 1'b1;
    #HALF;
    scl_lo = 1'b1;
    #HALF;
  endtask
  task automatic stop_cond();
    sda_lo = 1'b1;
    #HALF;
    scl_lo = 1'b0;
    #HALF;
    sda_lo = 1'b0;
    #HALF;
  endtask
  // A bit of one in tx releases SDA; the extra low time lets a slow slave grab SCL first.
  task automatic xfer(input logic [8:0] tx);
    #HALF;
    for (int i = 8; i >= 0; i--) begin
      sda_lo = !tx[i];
      #HALF;
      scl_lo = 1'b0;
      for (int k = 0; k < 8000 && scl !== 1'b1; k++) #10;
      #(HALF / 2);
      rx_word[i] = sda;
      #(HALF / 2);
      scl_lo = 1'b1;
    end
    -> got;
  endtask
endmodule

// File: verif/sst_slave_tx_checker.sv
`timescale 1ns/10ps
module sst_slave_tx_checker
  import sst_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  hold_at_low_a: assert property ($rose(scl_oe) |-> !$past(scl_in) && scl_out == 1'b0)
    else $error("scl hold began outside a low phase");
  sda_low_change_a: assert property ($changed(sda_oe) |-> !scl_in && sda_out == 1'b0)
    else $error("sda changed while scl high");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read answer cycle");
  release_scl_a: assert property (reg_wr && reg_addr == SST_REG_CTRL1 && reg_wdata[SST_C1_CKR]
    |=> !scl_oe) else $error("clock release write did not free scl");
  hold_stays_a: assert property (scl_oe && !(reg_wr && reg_addr == SST_REG_CTRL1)
    |=> scl_oe) else $error("scl hold dropped without release write");
  hold_sda_free_a: assert property ($rose(scl_oe) |-> !sda_oe)
    else $error("sda still driven when scl hold began");
  irq_fall_cause_a: assert property ($fell(irq) |-> $past(reg_rd) || $past(reg_wr)
    || $past(reg_rd, 2) || $past(reg_wr, 2)) else $error("irq fell without register access");
  own_addr_rw_a: assert property (reg_wr && reg_addr == SST_REG_ADDR ##1 !reg_wr ##1 reg_rd
    && reg_addr == SST_REG_ADDR |=> reg_rdata == ($past(reg_wdata, 3) & 8'h7f))
    else $error("own address readback wrong");
endmodule

// File: verif/sst_slave_tx_tb.sv
`timescale 1ns/10ps
module sst_slave_tx_tb
  import sst_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] reg_rdata;
  logic scl_out, scl_oe, sda_out, sda_oe, irq, m_scl_lo, m_sda_lo;
  logic [8:0] rx_word;
  logic [7:0] q_exp[$];
  logic [7:0] q_msk[$];
  logic [8:0] q_bus[$];
  int n_errors = 0;
  int samples_checked = 0;
  integer seed = 32'h1aea85e7;
  wire scl_w = !(m_scl_lo | (scl_oe & !scl_out));
  wire sda_w = !(m_sda_lo | (sda_oe & !sda_out));
  always #5 ref_clk = !ref_clk;
  sst_slave_tx dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq));
  sst_i2c_master u_master (.scl(scl_w), .sda(sda_w), .scl_lo(m_scl_lo), .sda_lo(m_sda_lo),
    .rx_word(rx_word));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Each access waits an edge first, so a strobe is never lowered and raised in one step.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    q_exp.push_back(e);
    q_msk.push_back(m);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic bus(input logic [8:0] tx, input logic [8:0] exp);
    q_bus.push_back(exp);
    u_master.xfer(tx);
  endtask
  task automatic service(input logic [7:0] d, input logic first);
    for (int i = 0; i < 200 && scl_oe !== 1'b1; i++) @(posedge ref_clk);
    check({8'h00, scl_oe}, 9'h001);
    check({8'h00, irq}, 9'h001);
    rd(SST_REG_IRQ, 8'h01, 8'h03);
    if (first) begin
      rd(SST_REG_STATUS, 8'h25, 8'h25);
      rd(SST_REG_DATA, 8'h63, 8'hff);
      rd(SST_REG_STATUS, 8'h24, 8'h25);
    end
    wr(SST_REG_DATA, d);
    wr(SST_REG_CTRL1, 8'h10);
  endtask
  always @(posedge ref_clk) begin
    if (rd_d && q_exp.size() > 0) begin
      check({1'b0, reg_rdata & q_msk[0]}, {1'b0, q_exp[0] & q_msk[0]});
      void'(q_exp.pop_front());
      void'(q_msk.pop_front());
    end
    rd_d <= reg_rd;
  end
  always @(u_master.got) begin
    if (q_bus.size() > 0) check(rx_word, q_bus.pop_front());
  end
  initial begin
    logic [7:0] d1;
    logic [7:0] d2;
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(SST_REG_ADDR, SST_RST_ADDR, 8'h7f);
    rd(SST_REG_CTRL1, SST_RST_CTRL1, 8'hff);
    wr(SST_REG_STATUS, 8'hff);
    rd(SST_REG_STATUS, 8'h00, 8'h3d);
    wr(SST_REG_ADDR, 8'h31);
    rd(SST_REG_ADDR, 8'h31, 8'h7f);
    wr(SST_REG_MASK, 8'h03);
    wr(SST_REG_CTRL3, 8'h24);
    u_master.start_cond();
    bus({7'h2a, 2'b11}, {7'h2a, 2'b11});
    u_master.stop_cond();
    rd(SST_REG_IRQ, 8'h01, 8'h01);
    u_master.start_cond();
    rd(SST_REG_STATUS, 8'h08, 8'h08);
    bus({7'h31, 2'b11}, {7'h31, 2'b10});
    fork
      bus({8'hff, 1'b0}, {d1, 1'b0});
      service(d1, 1'b1);
    join
    fork
      bus({8'hff, 1'b1}, {d2, 1'b1});
      service(d2, 1'b0);
    join
    repeat (20) @(posedge ref_clk);
    check({8'h00, scl_oe}, 9'h000);
    check({8'h00, irq}, 9'h001);
    wr(SST_REG_MASK, 8'h00);
    repeat (2) @(posedge ref_clk);
    check({8'h00, irq}, 9'h000);
    wr(SST_REG_MASK, 8'h03);
    rd(SST_REG_CTRL2, 8'h40, 8'h40);
    rd(SST_REG_IRQ, 8'h01, 8'h01);
    bus({8'hff, 1'b1}, {8'hff, 1'b1});
    u_master.stop_cond();
    rd(SST_REG_STATUS, 8'h00, 8'h20);
    u_master.start_cond();
    bus({7'h31, 2'b11}, {7'h31, 2'b10});
    fork
      bus({8'h7f, 1'b1}, {8'h7f, 1'b1});
      service(8'h80, 1'b0);
    join
    rd(SST_REG_IRQ, 8'h02, 8'h02);
    u_master.stop_cond();
    repeat (4) @(posedge ref_clk);
    test_done();
  end
  initial begin
    #400000;
    n_errors++;
    test_done();
  end
endmodule
bind sst_slave_tx sst_slave_tx_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
